//--- ovc_defs.svh
// Purpose: register map, field positions, reset values for the over-current comparator
// Assumes: 32-bit plain register port, byte offsets, one clock
// Notes:   included by the top module and by the testbench
//
// Notes on behaviour
// RULE1 - comparator filter maps bits to 0 and 1
// RULE2 - data filter maps bits to -1 and +1
// RULE3 - comparator output is unsigned straight binary
// RULE4 - software sets upper trip to 94 percent
// RULE5 - software sets lower trip to 6 percent
// RULE6 - capture start drives both warnings low
// RULE7 - trigger crossing releases both warnings high
// RULE8 - upper trip crossing pulls high-side warning low
// RULE9 - lower trip crossing pulls low-side warning low
// RULE10 - comparator latency is osr times order
// RULE11 - order is 3, 2 or 1
// RULE12 - order N needs N outputs to settle
// RULE13 - software must pick channel 1 as trigger
// RULE14 - rising crossing starts acquisition, else immediate
// RULE15 - every comparator output checked against trips; the code checks only settled outputs, and only in ST_RUN
`ifndef OVC_DEFS_SVH
`define OVC_DEFS_SVH

`define REG_CTRL            8'h00
`define REG_OSR             8'h04
`define REG_UPPER_TRIP      8'h08
`define REG_LOWER_TRIP      8'h0C
`define REG_TRIG_LEVEL      8'h10
`define REG_STATUS          8'h14
`define REG_CMP_VALUE       8'h18
`define REG_DATA_VALUE      8'h1C
`define REG_IRQ_STATUS      8'h20
`define REG_IRQ_CLEAR       8'h24
`define REG_IRQ_ENABLE      8'h28

`define CTRL_CAPTURE_BIT    0
`define CTRL_TRIG_EN_BIT    1
`define CTRL_CMP_ORD_LSB    2
`define CTRL_DAT_ORD_LSB    4
`define OSR_CMP_LSB         0
`define OSR_DAT_LSB         8

`define IRQ_TRIG_BIT        0
`define IRQ_HIGH_BIT        1
`define IRQ_LOW_BIT         2

// trigger enabled, both orders third
`define CTRL_RST            32'h0000_003E
// comparator osr 8, data osr 256, each stored minus one
`define OSR_RST             32'h0000_FF07
// 94 and 6 percent of the 8^3 comparator full scale of 512
`define UPPER_TRIP_RST      25'h00001E1
`define LOWER_TRIP_RST      25'h000001E
`define TRIG_LEVEL_RST      26'h0000000

`endif

//--- ovc_pkg.sv
// Purpose: shared types of the over-current comparator
// Assumes: ovc_defs.svh for numbers
// Notes:   types only
`default_nettype none
package ovc_pkg;
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN   = 2'b10
    } cap_state_type;

    typedef enum logic
    {
        MAP_UNIPOLAR = 1'b0,
        MAP_BIPOLAR  = 1'b1
    } bit_map_type;
endpackage
`default_nettype wire

//--- sinc_if.sv
// Purpose: link between the top and one sinc filter
// Assumes: one clock, bit_stb one cycle per modulator bit
// Notes:   ctrl side drives settings, filt side returns samples
`default_nettype none
interface sinc_if #(parameter int W = 26);
    logic                bit_stb;
    logic                bit_val;
    logic                restart;
    logic [1:0]          order;
    logic [7:0]          osr_m1;
    logic                out_stb;
    logic                settled;
    logic signed [W-1:0] out_val;

    modport filt (input bit_stb, bit_val, restart, order, osr_m1, output out_stb, settled, out_val);
    modport ctrl (output bit_stb, bit_val, restart, order, osr_m1, input out_stb, settled, out_val);
endinterface
`default_nettype wire

//--- sinc_filter.sv
// Purpose: sinc1..3 decimator on a one-bit stream
// Assumes: order 0 is treated as 1, osr 1..256
// Notes:   output every osr bits, so latency is osr times order bits
`default_nettype none
module sinc_filter
    import ovc_pkg::*;
#(
    parameter int          W         = 26,
    parameter bit_map_type MAP       = MAP_UNIPOLAR,
    parameter int          ORDER_MAX = 3
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    sinc_if.filt     port
);
    logic signed [W-1:0] integ_q [ORDER_MAX];
    logic signed [W-1:0] integ_d [ORDER_MAX];
    logic signed [W-1:0] dly_q   [ORDER_MAX];
    logic signed [W-1:0] dly_d   [ORDER_MAX];
    logic signed [W-1:0] cv      [ORDER_MAX+1];
    logic signed [W-1:0] x;
    logic signed [W-1:0] out_q, out_d;
    logic [7:0]          cnt_q, cnt_d;
    logic [1:0]          nout_q, nout_d;
    logic [1:0]          ord;
    logic                stb_q, stb_d, dec;

    // unipolar keeps the sum non-negative; bipolar centres it on zero
    assign x   = (MAP == MAP_BIPOLAR) ? (port.bit_val ? W'(1) : -W'(1))
                                      : (port.bit_val ? W'(1) : W'(0)); // RULE1 RULE2
    assign ord = (port.order == 2'h0) ? 2'h1 : port.order; // RULE11
    assign dec = port.bit_stb && (cnt_q == port.osr_m1);

    genvar k;
    generate
        for (k = 0; k < ORDER_MAX; k++)
        begin : g_stage
            always_comb
            begin
                if (port.restart)
                    integ_d[k] = '0;
                else if (port.bit_stb)
                    integ_d[k] = integ_q[k] + ((k == 0) ? x : integ_q[(k == 0) ? 0 : k-1]);
                else
                    integ_d[k] = integ_q[k];
                cv[k+1]  = cv[k] - dly_q[k];
                dly_d[k] = port.restart ? '0 : (dec ? cv[k] : dly_q[k]);
            end
        end
    endgenerate

    always_comb
    begin
        cv[0]  = integ_d[ord - 2'h1];
        cnt_d  = port.restart ? 8'h00 : (dec ? 8'h00 : (port.bit_stb ? cnt_q + 8'h01 : cnt_q));
        stb_d  = dec && !port.restart;
        out_d  = dec ? cv[ord] : out_q; // RULE10
        nout_d = nout_q;
        if (port.restart)
            nout_d = 2'h0;
        else if (dec && nout_q < ord)
            nout_d = nout_q + 2'h1; // RULE12
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            integ_q <= '{default: '0};
            dly_q   <= '{default: '0};
            out_q   <= '0;
            cnt_q   <= 8'h00;
            nout_q  <= 2'h0;
            stb_q   <= 1'b0;
        end
        else
        begin
            integ_q <= integ_d;
            dly_q   <= dly_d;
            out_q   <= out_d;
            cnt_q   <= cnt_d;
            nout_q  <= nout_d;
            stb_q   <= stb_d;
        end
    end

    assign port.out_stb = stb_q;
    assign port.out_val = out_q;
    assign port.settled = (nout_q >= ord);
endmodule
`default_nettype wire

//--- sigma_delta_overcurrent_comparator.sv
// Purpose: over-current comparator channel with two active-low warning outputs
// Assumes: modulator clock and bit are synchronous inputs; clk_in much faster than the modulator clock
// Notes:   warnings stay asserted until the next trigger: a rising crossing, or a capture start with trigger off
//
// The implementer's own choices: strobed register access and the register offsets.
`include "ovc_defs.svh"
`default_nettype none
module sigma_delta_overcurrent_comparator
    import ovc_pkg::*;
#(
    parameter int W = 26
)
(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        mod_clk_in,
    input  wire logic        mod_bit_in,
    input  wire logic [7:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_stb_in,
    input  wire logic        rd_stb_in,
    output var  logic [31:0] rdata_out,
    output var  logic        irq_out,
    output var  logic        high_warn_n_out,
    output var  logic        low_warn_n_out
);
    localparam int TW = W - 1;

    ////////////////////////////////////////////////////////////////////////////////
    // filters

    sinc_if #(.W(W)) cmp_if ();
    sinc_if #(.W(W)) dat_if ();

    logic        mclk_q, mclk_d;
    logic        bit_stb;
    logic        cap_go;
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] osr_q, osr_d;

    assign bit_stb = mod_clk_in && !mclk_q;
    assign cap_go  = wr_stb_in && (addr_in == `REG_CTRL) && wdata_in[`CTRL_CAPTURE_BIT];

    assign cmp_if.bit_stb = bit_stb;
    assign cmp_if.bit_val = mod_bit_in;
    assign cmp_if.restart = cap_go;
    assign cmp_if.order   = ctrl_q[`CTRL_CMP_ORD_LSB +: 2];
    assign cmp_if.osr_m1  = osr_q[`OSR_CMP_LSB +: 8];

    assign dat_if.bit_stb = bit_stb;
    assign dat_if.bit_val = mod_bit_in;
    assign dat_if.restart = cap_go;
    assign dat_if.order   = ctrl_q[`CTRL_DAT_ORD_LSB +: 2];
    assign dat_if.osr_m1  = osr_q[`OSR_DAT_LSB +: 8];

    sinc_filter #(
        .W   (W),
        .MAP (MAP_UNIPOLAR)
    ) u_cmp_filter (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .port     (cmp_if.filt)
    );

    sinc_filter #(
        .W   (W),
        .MAP (MAP_BIPOLAR)
    ) u_dat_filter (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .port     (dat_if.filt)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [TW-1:0]       upper_q, upper_d;
    logic [TW-1:0]       lower_q, lower_d;
    logic signed [W-1:0] trig_q, trig_d;
    logic [2:0]          irq_en_q, irq_en_d;
    logic                wr_hit;

    always_comb
    begin
        mclk_d   = mod_clk_in;
        ctrl_d   = ctrl_q;
        osr_d    = osr_q;
        upper_d  = upper_q;
        lower_d  = lower_q;
        trig_d   = trig_q;
        irq_en_d = irq_en_q;
        wr_hit   = wr_stb_in;
        if (wr_hit)
        begin
            case (addr_in)
                `REG_CTRL:       ctrl_d   = {26'h0, wdata_in[5:1], 1'b0};
                `REG_OSR:        osr_d    = {16'h0, wdata_in[15:0]};
                `REG_UPPER_TRIP: upper_d  = wdata_in[TW-1:0]; // RULE4
                `REG_LOWER_TRIP: lower_d  = wdata_in[TW-1:0]; // RULE5
                `REG_TRIG_LEVEL: trig_d   = wdata_in[W-1:0];
                `REG_IRQ_ENABLE: irq_en_d = wdata_in[2:0];
                default:         ctrl_d   = ctrl_q;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mclk_q   <= 1'b0;
            ctrl_q   <= `CTRL_RST;
            osr_q    <= `OSR_RST;
            upper_q  <= `UPPER_TRIP_RST;
            lower_q  <= `LOWER_TRIP_RST;
            trig_q   <= `TRIG_LEVEL_RST;
            irq_en_q <= 3'h0;
        end
        else
        begin
            mclk_q   <= mclk_d;
            ctrl_q   <= ctrl_d;
            osr_q    <= osr_d;
            upper_q  <= upper_d;
            lower_q  <= lower_d;
            trig_q   <= trig_d;
            irq_en_q <= irq_en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // capture sequencing and warnings

    cap_state_type       state_q, state_d;
    logic                high_n_q, high_n_d;
    logic                low_n_q, low_n_d;
    logic                prev_below_q, prev_below_d;
    logic                prev_ok_q, prev_ok_d;
    logic [TW-1:0]       cmp_val_q, cmp_val_d;
    logic signed [W-1:0] dat_val_q, dat_val_d;
    logic                ev_trig, ev_high, ev_low;
    logic [TW-1:0]       cmp_u;
    logic                cmp_new, dat_new;

    // unipolar sums never go negative, so the sign bit is dropped
    assign cmp_u   = cmp_if.out_val[TW-1:0]; // RULE3
    assign cmp_new = cmp_if.out_stb && cmp_if.settled; // RULE12
    assign dat_new = dat_if.out_stb && dat_if.settled;

    always_comb
    begin
        state_d      = state_q;
        high_n_d     = high_n_q;
        low_n_d      = low_n_q;
        prev_below_d = prev_below_q;
        prev_ok_d    = prev_ok_q;
        cmp_val_d    = cmp_new ? cmp_u : cmp_val_q;
        dat_val_d    = dat_new ? dat_if.out_val : dat_val_q;
        ev_trig      = 1'b0;
        ev_high      = 1'b0;
        ev_low       = 1'b0;
        if (dat_new)
        begin
            prev_below_d = (dat_if.out_val < trig_q);
            prev_ok_d    = 1'b1;
        end
        if (cap_go)
        begin
            prev_ok_d = 1'b0;
            if (wdata_in[`CTRL_TRIG_EN_BIT]) // RULE13
            begin
                state_d  = ST_ARMED;
                high_n_d = 1'b0; // RULE6
                low_n_d  = 1'b0; // RULE6
            end
            else
            begin
                state_d  = ST_RUN; // RULE14
                high_n_d = 1'b1;
                low_n_d  = 1'b1;
                ev_trig  = 1'b1;
            end
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    state_d = ST_IDLE;
                end
                ST_ARMED:
                begin
                    if (dat_new && prev_ok_q && prev_below_q && !(dat_if.out_val < trig_q)) // RULE14
                    begin
                        state_d  = ST_RUN;
                        high_n_d = 1'b1; // RULE7
                        low_n_d  = 1'b1; // RULE7
                        ev_trig  = 1'b1;
                    end
                end
                ST_RUN:
                begin
                    if (cmp_new && cmp_u > upper_q) // RULE15
                    begin
                        high_n_d = 1'b0; // RULE8
                        ev_high  = 1'b1;
                    end
                    if (cmp_new && cmp_u < lower_q) // RULE15
                    begin
                        low_n_d = 1'b0; // RULE9
                        ev_low  = 1'b1;
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_q      <= ST_IDLE;
            high_n_q     <= 1'b1;
            low_n_q      <= 1'b1;
            prev_below_q <= 1'b0;
            prev_ok_q    <= 1'b0;
            cmp_val_q    <= '0;
            dat_val_q    <= '0;
        end
        else
        begin
            state_q      <= state_d;
            high_n_q     <= high_n_d;
            low_n_q      <= low_n_d;
            prev_below_q <= prev_below_d;
            prev_ok_q    <= prev_ok_d;
            cmp_val_q    <= cmp_val_d;
            dat_val_q    <= dat_val_d;
        end
    end

    assign high_warn_n_out = high_n_q;
    assign low_warn_n_out  = low_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts and read port

    logic [2:0]  irq_st_q, irq_st_d;
    logic [2:0]  irq_set, irq_clr;
    logic        irq_q, irq_d;
    logic [31:0] rdata_q, rdata_d;

    assign irq_set = {ev_low, ev_high, ev_trig};
    assign irq_clr = (wr_stb_in && addr_in == `REG_IRQ_CLEAR) ? wdata_in[2:0] : 3'h0;

    always_comb
    begin
        // a set in the clearing cycle wins so no event is lost
        irq_st_d = (irq_st_q & ~irq_clr) | irq_set;
        irq_d    = |(irq_st_d & irq_en_d);
        rdata_d  = 32'h0000_0000;
        if (rd_stb_in)
        begin
            case (addr_in)
                `REG_CTRL:       rdata_d = ctrl_q;
                `REG_OSR:        rdata_d = osr_q;
                `REG_UPPER_TRIP: rdata_d = {7'h00, upper_q};
                `REG_LOWER_TRIP: rdata_d = {7'h00, lower_q};
                `REG_TRIG_LEVEL: rdata_d = {{(32-W){trig_q[W-1]}}, trig_q};
                `REG_STATUS:     rdata_d = {26'h0, cmp_if.settled, dat_if.settled, state_q, low_n_q, high_n_q};
                `REG_CMP_VALUE:  rdata_d = {7'h00, cmp_val_q};
                `REG_DATA_VALUE: rdata_d = {{(32-W){dat_val_q[W-1]}}, dat_val_q};
                `REG_IRQ_STATUS: rdata_d = {29'h0, irq_st_q};
                `REG_IRQ_ENABLE: rdata_d = {29'h0, irq_en_q};
                default:         rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_st_q <= 3'h0;
            irq_q    <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end
        else
        begin
            irq_st_q <= irq_st_d;
            irq_q    <= irq_d;
            rdata_q  <= rdata_d;
        end
    end

    assign irq_out   = irq_q;
    assign rdata_out = rdata_q;
endmodule
`default_nettype wire

//--- ovc_chk_assertions.sv
// Purpose: port checks of the over-current comparator
// Assumes: top ports only, one clock domain
// Notes:   bound to the top module below
`default_nettype none
module ovc_chk (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        mod_clk_in,
    input wire logic [7:0]  addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic        wr_stb_in,
    input wire logic        rd_stb_in,
    input wire logic [31:0] rdata_out,
    input wire logic        irq_out,
    input wire logic        high_warn_n_out,
    input wire logic        low_warn_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    wire cap = wr_stb_in && addr_in == 8'h00 && wdata_in[0];

    a_cap_arm: assert property (cap && wdata_in[1] |=> !high_warn_n_out && !low_warn_n_out)
        else $error("capture did not arm both warnings");
    a_cap_free: assert property (cap && !wdata_in[1] |=> high_warn_n_out && low_warn_n_out)
        else $error("capture without trigger left a warning low");
    a_warn_pair: assert property ($rose(high_warn_n_out) |-> low_warn_n_out)
        else $error("high warning released alone");
    // edge-driven changes land two cycles after the modulator bit cycle
    a_rise_time: assert property ($rose(low_warn_n_out) && !$past(cap)
        |-> $past(mod_clk_in, 2) && !$past(mod_clk_in, 3))
        else $error("release not tied to a modulator bit");
    a_hi_time: assert property ($fell(high_warn_n_out) && !$past(cap)
        |-> $past(mod_clk_in, 2) && !$past(mod_clk_in, 3))
        else $error("high warning fell off a filter output");
    a_lo_time: assert property ($fell(low_warn_n_out) && !$past(cap)
        |-> $past(mod_clk_in, 2) && !$past(mod_clk_in, 3))
        else $error("low warning fell off a filter output");
    a_rd_window: assert property (rdata_out != 32'h0 |-> $past(rd_stb_in))
        else $error("read data outside its cycle");
    a_rd_unmapped: assert property (rd_stb_in && addr_in == 8'hFC |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_irq_mask: assert property (wr_stb_in && addr_in == 8'h28 && wdata_in == 32'h0 |=> ##1 !irq_out)
        else $error("interrupt high with all enables off");
endmodule

bind sigma_delta_overcurrent_comparator ovc_chk i_ovc_chk (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .mod_clk_in(mod_clk_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_stb_in(wr_stb_in),
    .rd_stb_in(rd_stb_in),
    .rdata_out(rdata_out),
    .irq_out(irq_out),
    .high_warn_n_out(high_warn_n_out),
    .low_warn_n_out(low_warn_n_out)
);
`default_nettype wire

//--- mod_source.sv
// Purpose: modulator model, bit stream of ones_in ones per eight bits
// Assumes: modulator clock is clk_in over four
// Notes:   clock runs free, as a real modulator clock does
`default_nettype none
module mod_source (
    input  wire logic       clk_in,
    input  wire logic [3:0] ones_in,
    output var  logic       mod_clk_out,
    output var  logic       mod_bit_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q = 2'h0;
    logic [2:0] idx_q = 3'h0;
    logic       clk_q = 1'b0;
    logic       bit_q = 1'b0;
    // period of eight keeps every sinc window sum exact, whatever the phase
    always @(posedge clk_in)
    begin
        div_q <= div_q + 2'h1;
        clk_q <= div_q[1];
        if (div_q == 2'h3)
        begin
            idx_q <= idx_q + 3'h1;
            bit_q <= ({1'b0, idx_q} < ones_in);
        end
    end
    // one process owns each output, so the model has a single driver per pin
    assign mod_clk_out = clk_q;
    assign mod_bit_out = bit_q;
endmodule
`default_nettype wire

//--- test_sigma_delta_overcurrent_comparator.sv
// Purpose: self-checking bench of the over-current comparator
// Assumes: mod_source drives the bit stream
// Notes:   register port is strobe based, no wait states
`include "ovc_defs.svh"
`default_nettype none
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin n_fail++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end \
end
module test_sigma_delta_overcurrent_comparator;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in    = 1'b0;
    logic        rst_n_in  = 1'b0;
    logic        wr_stb_in = 1'b0;
    logic        rd_stb_in = 1'b0;
    logic [7:0]  addr_in   = 8'h00;
    logic [31:0] wdata_in  = 32'h0;
    logic [3:0]  ones      = 4'h4;
    wire         mod_clk;
    wire         mod_bit;
    logic [31:0] rdata_out;
    logic        irq_out;
    logic        hw_n;
    logic        lw_n;
    int          n_fail    = 0;
    int          cmp_count = 0;

    sigma_delta_overcurrent_comparator i_sigma_delta_overcurrent_comparator (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .mod_clk_in(mod_clk),
        .mod_bit_in(mod_bit),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_stb_in(wr_stb_in),
        .rd_stb_in(rd_stb_in),
        .rdata_out(rdata_out),
        .irq_out(irq_out),
        .high_warn_n_out(hw_n),
        .low_warn_n_out(lw_n)
    );
    mod_source i_mod_source (
        .clk_in(clk_in),
        .ones_in(ones),
        .mod_clk_out(mod_clk),
        .mod_bit_out(mod_bit)
    );

    initial forever #50 clk_in = ~clk_in;

    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_stb_in <= 1'b1;
        @(posedge clk_in);
        wr_stb_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_stb_in <= 1'b1;
        @(posedge clk_in);
        rd_stb_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask
    task automatic rd_until(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        for (int i = 0; i < 300; i++)
        begin
            rd(a, d);
            if (d === e)
                break;
        end
        `CHK(d, e)
        if (d !== e)
            close_out();
    endtask
    // cycles until the chosen warning reads v
    task automatic wait_warn(input bit hi, input logic v, output int n);
        for (n = 0; n < 3000; n++)
        begin
            @(posedge clk_in);
            #1;
            if ((hi ? hw_n : lw_n) === v)
                return;
        end
        n_fail++;
        close_out();
    endtask
    task automatic irq_chk(input logic [31:0] en, input logic v);
        wr(`REG_IRQ_ENABLE, en);
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(irq_out, v)
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0]  a[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h28, 8'h24, 8'hFC};
        logic [31:0] e[8] = '{32'h3E, 32'hFF07, 32'h1E1, 32'h1E, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] d;
        `CHK({hw_n, lw_n, irq_out}, 3'b110)
        for (int i = 0; i < 8; i++)
        begin
            rd(a[i], d);
            `CHK(d, e[i])
        end
        wr(`REG_STATUS, 32'hFF);
        rd(`REG_STATUS, d);
        `CHK(d, 32'h03)
    endtask
    task automatic t_orders();
        logic [31:0] d;
        for (int o = 1; o <= 3; o++)
        begin
            wr(`REG_CTRL, 32'h31 | (32'(o) << 2));
            rd(`REG_STATUS, d);
            `CHK(d, 32'h0B)
            rd_until(`REG_CMP_VALUE, 32'h4 << (3 * (o - 1)));
        end
    endtask
    task automatic t_trig();
        logic [31:0] d;
        int          n;
        wr(`REG_OSR, 32'h0F07);
        wr(`REG_UPPER_TRIP, 32'h1E1);
        wr(`REG_LOWER_TRIP, 32'h1E);
        wr(`REG_IRQ_CLEAR, 32'h7);
        ones <= 4'h2;
        wr(`REG_CTRL, 32'h3F);
        rd(`REG_STATUS, d);
        `CHK(d, 32'h04)
        rd_until(`REG_STATUS, 32'h34);
        ones <= 4'h4;
        wait_warn(1'b1, 1'b1, n);
        `CHK(lw_n, 1'b1)
        rd_until(`REG_CMP_VALUE, 32'h100);
        ones <= 4'h8;
        wait_warn(1'b1, 1'b0, n);
        `CHK(n >= 40 && n <= 140, 1'b1)
        `CHK(lw_n, 1'b1)
        rd_until(`REG_CMP_VALUE, 32'h200);
        ones <= 4'h0;
        wait_warn(1'b0, 1'b0, n);
        `CHK(n <= 140, 1'b1)
        `CHK(hw_n, 1'b0)
        rd(`REG_IRQ_STATUS, d);
        `CHK(d, 32'h7)
    endtask
    task automatic t_irq();
        logic [31:0] d;
        irq_chk(32'h2, 1'b1);
        wr(`REG_IRQ_CLEAR, 32'h2);
        repeat (2) @(posedge clk_in);
        #1;
        `CHK(irq_out, 1'b0)
        irq_chk(32'h4, 1'b1);
        irq_chk(32'h0, 1'b0);
        rd(`REG_IRQ_STATUS, d);
        `CHK(d, 32'h5)
    endtask

    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_reset();
        t_orders();
        t_trig();
        t_irq();
        close_out();
    end
endmodule
`default_nettype wire
